// file: core/cacb_pkg.sv
package cacb_pkg;

    // Clock rate and calibration durations in their own units.
    localparam int CLK_HZ       = 20_000_000;
    localparam int SYS_CAL_MS   = 100;
    localparam int SELF_CAL_MS  = 200;
    localparam int SYS_CAL_CYC  = SYS_CAL_MS * (CLK_HZ / 1000);
    localparam int SELF_CAL_CYC = SELF_CAL_MS * (CLK_HZ / 1000);
    localparam int CNT_W        = 22;

    // Clocks between the first busy pipeline stage and the ready edge.
    localparam int UPD_WIN_CYC  = 4;

    // Coefficient and datapath shapes.
    localparam int COEF_W       = 24;
    localparam int GAIN_FRAC    = 22;
    localparam logic [4:0] LAST_BIT = 5'h17;

    // Serial register indices: bit 2 selects the working copy.
    localparam int         WORK_SEL_BIT     = 2;
    localparam logic [2:0] IDX_SYS_OFF_STG  = 3'h0;
    localparam logic [2:0] IDX_SYS_GAIN_STG = 3'h1;
    localparam logic [2:0] IDX_SC_OFF_STG   = 3'h2;
    localparam logic [2:0] IDX_SC_GAIN_STG  = 3'h3;
    localparam logic [2:0] IDX_SYS_OFF_WRK  = 3'h4;
    localparam logic [2:0] IDX_SYS_GAIN_WRK = 3'h5;
    localparam logic [2:0] IDX_SC_OFF_WRK   = 3'h6;
    localparam logic [2:0] IDX_SC_GAIN_WRK  = 3'h7;

    // Calibration type field encodings.
    localparam logic [1:0] CAL_SELF     = 2'h0;
    localparam logic [1:0] CAL_SYS_ZERO = 2'h1;
    localparam logic [1:0] CAL_SYS_FULL = 2'h2;

    // Reset values: zero offset and unity gain.
    localparam logic [23:0] OFFSET_RST = 24'h00_0000;
    localparam logic [23:0] GAIN_RST   = 24'h40_0000;

    typedef struct packed {
        logic [1:0] cal_type;
        logic       system_gain_disable;
        logic       system_offset_disable;
        logic       selfcal_gain_disable;
        logic       selfcal_offset_disable;
        logic       unipolar;
    } cacb_ctrl_t;

    typedef struct packed {
        logic [2:0] addr;
        logic       write;
    } cacb_access_t;

    typedef enum {CAL_IDLE, CAL_SELF_RUN, CAL_SYS_OFF_RUN, CAL_SYS_GAIN_RUN} cacb_cal_state_t;

endpackage

// file: core/cacb_shift.sv
`timescale 1ns/10ps
module cacb_shift (
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        load,
    input  wire logic [23:0] load_word,
    input  wire logic        bit_strobe,
    input  wire logic        bit_in,
    output logic             bit_out,
    output logic [23:0]      word,
    output logic             done
);
    logic [23:0] sh_q;
    logic [4:0]  cnt_q;
    logic        done_q;

    // One register serves both directions, MSB leaving and entering first.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            sh_q <= 24'h00_0000;
        end else if (load) begin
            sh_q <= load_word;
        end else if (bit_strobe) begin
            sh_q <= {sh_q[22:0], bit_in};
        end
    end

    // Bit counter wraps after a full word so a burst may continue.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 5'h00;
        end else if (load) begin
            cnt_q <= 5'h00;
        end else if (bit_strobe) begin
            cnt_q <= (cnt_q == cacb_pkg::LAST_BIT) ? 5'h00 : cnt_q + 5'h01;
        end
    end

    // Word complete pulse, one cycle after the last bit.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            done_q <= 1'b0;
        end else begin
            done_q <= !load && bit_strobe && (cnt_q == cacb_pkg::LAST_BIT);
        end
    end

    assign bit_out = sh_q[23];
    assign word    = sh_q;
    assign done    = done_q;

    ////////////////////////////////////////////////////////////////////////
    property p_msb_first;
        @(posedge clock) disable iff (!arst_n)
        load |=> bit_out == $past(load_word[23]);
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("MSB not first out.");

    cover property (@(posedge clock) disable iff (!arst_n) done_q);
endmodule // cacb_shift

// file: core/cacb_bank.sv
`timescale 1ns/10ps
module cacb_bank #(
    parameter int SYS_CAL_CYCLES  = cacb_pkg::SYS_CAL_CYC,
    parameter int SELF_CAL_CYCLES = cacb_pkg::SELF_CAL_CYC
) (
    input  wire logic                 clock,
    input  wire logic                 arst_n,
    input  wire logic                 cmd_valid,
    input  wire logic                 cmd_calibrate,
    input  wire cacb_pkg::cacb_ctrl_t correction_control_register,
    input  wire logic [23:0]          meas_offset,
    input  wire logic [23:0]          meas_gain,
    input  wire logic                 raw_valid,
    input  wire logic [23:0]          raw_data,
    input  wire logic                 acc_start,
    input  wire cacb_pkg::cacb_access_t acc,
    input  wire logic                 bit_strobe,
    input  wire logic                 bit_in,
    input  wire logic                 status_read,
    output logic                      bit_out,
    output logic                      word_done,
    output logic                      data_ready_n,
    output logic [23:0]               result_data,
    output logic                      read_error_flag,
    output logic                      cal_busy
);
    localparam int CW = cacb_pkg::CNT_W;
    localparam logic [CW-1:0] SYS_LAST  = CW'(SYS_CAL_CYCLES - 1);
    localparam logic [CW-1:0] SELF_LAST = CW'(SELF_CAL_CYCLES - 1);

    cacb_pkg::cacb_ctrl_t        ctl;
    cacb_pkg::cacb_cal_state_t   state_q;
    cacb_pkg::cacb_access_t      acc_q;
    logic [CW-1:0]               cnt_q;
    logic [1:0]                  cal_type_q;
    logic [23:0]                 stage_q [4];
    logic [23:0]                 work_q [4];
    logic [3:0]                  stage_ok_q;
    logic [23:0]                 shift_word;
    logic [23:0]                 read_word;
    logic                        busy_q;
    logic                        cal_done;
    logic                        cal_req;
    logic                        conv_req;
    logic                        wr_commit;
    logic                        window;
    logic                        rd_hit;
    logic                        rdy_n_q;
    logic                        read_error_flag_q;
    logic [23:0]                 res_q;
    logic [4:1]                  v_q;
    logic signed [26:0]          p1_q, p2_q, p3_q, p4_q;
    logic signed [26:0]          res_w;

    assign ctl = correction_control_register;

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers.

    // True when a serial index names a working copy.
    function automatic logic is_working(input logic [2:0] a);
        return a[cacb_pkg::WORK_SEL_BIT];
    endfunction

    // True when calibration type typ produces coefficient idx.
    function automatic logic cal_hits(input logic [1:0] typ, input logic [1:0] idx);
        unique case (typ)
            cacb_pkg::CAL_SELF:     return idx[1];
            cacb_pkg::CAL_SYS_ZERO: return idx == 2'h0;
            cacb_pkg::CAL_SYS_FULL: return idx == 2'h1;
            default:                return 1'b0;
        endcase
    endfunction

    // Offset in half-LSB two's complement, widened with headroom.
    function automatic logic signed [26:0] off_ext(input logic [23:0] o);
        return $signed({{3{o[23]}}, o});
    endfunction

    // Unsigned 2.22 gain times signed value, clamped to the path width.
    function automatic logic signed [26:0] gmul(input logic signed [26:0] x,
                                                input logic [23:0] g);
        logic signed [51:0] p;
        p = x * $signed({1'b0, g});
        if (p[51:48] == {4{p[51]}}) begin
            return p[48:22];
        end
        return p[51] ? 27'sh400_0000 : 27'sh3ff_ffff;
    endfunction

    // Clamp to 24-bit two's complement output.
    function automatic logic [23:0] sat24(input logic signed [26:0] x);
        if (x[26:23] == {4{x[26]}}) begin
            return x[23:0];
        end
        return x[26] ? 24'h80_0000 : 24'h7f_ffff;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Command decode.

    // A reserved type is dropped so a bad command never blocks conversions.
    assign cal_req  = cmd_valid && cmd_calibrate && (state_q == cacb_pkg::CAL_IDLE)
                      && (ctl.cal_type != 2'h3);
    assign conv_req = cmd_valid && !cmd_calibrate && (state_q == cacb_pkg::CAL_IDLE);
    assign cal_done = (state_q != cacb_pkg::CAL_IDLE)
                      && (cnt_q == ((state_q == cacb_pkg::CAL_SELF_RUN) ? SELF_LAST : SYS_LAST));

    // Calibration sequencer.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= cacb_pkg::CAL_IDLE;
        end else begin
            unique case (state_q)
                cacb_pkg::CAL_IDLE: begin
                    if (cal_req && ctl.cal_type == cacb_pkg::CAL_SELF) begin
                        state_q <= cacb_pkg::CAL_SELF_RUN;
                    end else if (cal_req && ctl.cal_type == cacb_pkg::CAL_SYS_ZERO) begin
                        state_q <= cacb_pkg::CAL_SYS_OFF_RUN;
                    end else if (cal_req) begin
                        state_q <= cacb_pkg::CAL_SYS_GAIN_RUN;
                    end
                end
                cacb_pkg::CAL_SELF_RUN, cacb_pkg::CAL_SYS_OFF_RUN,
                cacb_pkg::CAL_SYS_GAIN_RUN: begin
                    if (cal_done) begin
                        state_q <= cacb_pkg::CAL_IDLE;
                    end
                end
            endcase
        end
    end

    // Duration counter and latched type.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q      <= '0;
            cal_type_q <= 2'h0;
        end else begin
            cnt_q <= (state_q == cacb_pkg::CAL_IDLE || cal_done) ? '0 : cnt_q + 1'b1;
            if (cal_req) begin
                cal_type_q <= ctl.cal_type;
            end
        end
    end

    // Busy flag mirrors the sequencer state from a flop of its own.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busy_q <= 1'b0;
        end else begin
            busy_q <= (state_q == cacb_pkg::CAL_IDLE) ? cal_req : !cal_done;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial register access.

    assign read_word = is_working(acc.addr) ? work_q[acc.addr[1:0]] : stage_q[acc.addr[1:0]];
    // Write checked at word end, so a calibration started mid-word still blocks it.
    assign wr_commit = word_done && acc_q.write && !is_working(acc_q.addr)
                       && (state_q == cacb_pkg::CAL_IDLE);
    assign window    = |v_q;
    assign rd_hit    = acc_start && !acc.write && is_working(acc.addr) && window;

    // Remember the addressed register for the whole word.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            acc_q <= '0;
        end else if (acc_start) begin
            acc_q <= acc;
        end
    end

    cacb_shift u_shift (
        .clock      (clock),
        .arst_n     (arst_n),
        .load       (acc_start),
        .load_word  (read_word),
        .bit_strobe (bit_strobe),
        .bit_in     (bit_in),
        .bit_out    (bit_out),
        .word       (shift_word),
        .done       (word_done)
    );

    // Read error flag: a new hit wins over a clear in the same cycle.
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            read_error_flag_q <= 1'b0;
        end else if (rd_hit) begin
            read_error_flag_q <= 1'b1;
        end else if (status_read) begin
            read_error_flag_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Coefficient storage, one slice per coefficient.
    for (genvar i = 0; i < 4; i++) begin : g_coef
        localparam logic [1:0]  IDX = 2'(i);
        localparam logic [23:0] RST = IDX[0] ? cacb_pkg::GAIN_RST : cacb_pkg::OFFSET_RST;

        // Staging value holds until a fresh serial write lands.
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                stage_q[i] <= RST;
            end else if (wr_commit && acc_q.addr[1:0] == IDX) begin
                stage_q[i] <= shift_word;
            end
        end

        // Validity: a write revalidates and wins over a same-cycle request.
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                stage_ok_q[i] <= 1'b1;
            end else if (wr_commit && acc_q.addr[1:0] == IDX) begin
                stage_ok_q[i] <= 1'b1;
            end else if (cal_req && cal_hits(ctl.cal_type, IDX)) begin
                stage_ok_q[i] <= 1'b0;
            end
        end

        // Working copy: calibration result or staged copy, nothing else.
        always_ff @(posedge clock or negedge arst_n) begin
            if (!arst_n) begin
                work_q[i] <= RST;
            end else if (cal_done && cal_hits(cal_type_q, IDX)) begin
                work_q[i] <= IDX[0] ? meas_gain : meas_offset;
            end else if (conv_req && stage_ok_q[i]) begin
                work_q[i] <= stage_q[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Correction chain in half-LSB units; the extra bits carry gain headroom.

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            v_q <= 4'h0;
        end else begin
            v_q <= {v_q[3:1], raw_valid};
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            p1_q <= '0;
            p2_q <= '0;
            p3_q <= '0;
            p4_q <= '0;
        end else begin
            p1_q <= ctl.selfcal_offset_disable ? $signed({{2{raw_data[23]}}, raw_data, 1'b0})
                  : $signed({{2{raw_data[23]}}, raw_data, 1'b0}) - off_ext(work_q[2]);
            p2_q <= ctl.selfcal_gain_disable ? p1_q : gmul(p1_q, work_q[3]);
            p3_q <= ctl.system_offset_disable ? p2_q : p2_q - off_ext(work_q[0]);
            p4_q <= ctl.system_gain_disable ? p3_q : gmul(p3_q, work_q[1]);
        end
    end

    // Unipolar keeps the half-LSB scale, doubling the result; bipolar drops it.
    assign res_w = ctl.unipolar ? p4_q : (p4_q >>> 1);

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdy_n_q <= 1'b1;
            res_q   <= 24'h00_0000;
        end else begin
            rdy_n_q <= !v_q[4];
            if (v_q[4]) begin
                res_q <= sat24(res_w);
            end
        end
    end

    assign data_ready_n    = rdy_n_q;
    assign result_data     = res_q;
    assign read_error_flag = read_error_flag_q;
    assign cal_busy        = busy_q;

    ////////////////////////////////////////////////////////////////////////
    logic [95:0] stage_flat;
    assign stage_flat = {stage_q[0], stage_q[1], stage_q[2], stage_q[3]};

    property p_sys_off;
        @(posedge clock) disable iff (!arst_n)
        cal_done && cal_type_q == cacb_pkg::CAL_SYS_ZERO |=>
            work_q[0] == $past(meas_offset) && !cal_busy;
    endproperty
    a_sys_off: assert property (p_sys_off) else $error("System offset not loaded.");

    property p_sys_gain;
        @(posedge clock) disable iff (!arst_n)
        cal_done && cal_type_q == cacb_pkg::CAL_SYS_FULL |=> work_q[1] == $past(meas_gain);
    endproperty
    a_sys_gain: assert property (p_sys_gain) else $error("System gain not loaded.");

    property p_self;
        @(posedge clock) disable iff (!arst_n)
        cal_done && cal_type_q == cacb_pkg::CAL_SELF |=>
            work_q[2] == $past(meas_offset) && work_q[3] == $past(meas_gain);
    endproperty
    a_self: assert property (p_self) else $error("Self-cal values not loaded.");

    // Busy length as the host sees it, so the check does not lean on cal_done itself.
    logic [CW-1:0] busy_len_q;
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            busy_len_q <= '0;
        end else begin
            busy_len_q <= cal_busy ? busy_len_q + 1'b1 : '0;
        end
    end

    property p_cal_len;
        @(posedge clock) disable iff (!arst_n)
        $fell(cal_busy) |->
            busy_len_q == ((cal_type_q == cacb_pkg::CAL_SELF) ? SELF_LAST : SYS_LAST) + 1'b1;
    endproperty
    a_cal_len: assert property (p_cal_len) else $error("Calibration length wrong.");

    property p_write_blocked;
        @(posedge clock) disable iff (!arst_n)
        word_done && cal_busy |=> $stable(stage_flat);
    endproperty
    a_write_blocked: assert property (p_write_blocked) else $error("Write during cal.");

    property p_stage_hold;
        @(posedge clock) disable iff (!arst_n)
        !wr_commit |=> $stable(stage_flat);
    endproperty
    a_stage_hold: assert property (p_stage_hold) else $error("Staging value drifted.");

    property p_copy;
        @(posedge clock) disable iff (!arst_n)
        conv_req && stage_ok_q[1] |=> work_q[1] == $past(stage_q[1]);
    endproperty
    a_copy: assert property (p_copy) else $error("Staged value not copied.");

    property p_work_ro;
        @(posedge clock) disable iff (!arst_n)
        $changed(work_q[0]) |-> $past(cal_done || conv_req);
    endproperty
    a_work_ro: assert property (p_work_ro) else $error("Working register changed.");

    property p_inval;
        @(posedge clock) disable iff (!arst_n)
        cal_req && ctl.cal_type == cacb_pkg::CAL_SYS_ZERO && !wr_commit |=> !stage_ok_q[0];
    endproperty
    a_inval: assert property (p_inval) else $error("Staging not invalidated.");

    property p_ready;
        @(posedge clock) disable iff (!arst_n)
        raw_valid |-> ##5 !data_ready_n;
    endproperty
    a_ready: assert property (p_ready) else $error("Ready latency wrong.");

    property p_read_error_flag;
        @(posedge clock) disable iff (!arst_n)
        acc_start && !acc.write && is_working(acc.addr) && window |=> read_error_flag;
    endproperty
    a_read_error_flag: assert property (p_read_error_flag) else $error("Read error not flagged.");

    cover property (@(posedge clock) disable iff (!arst_n) cal_done && cal_type_q == 2'h0);
    cover property (@(posedge clock) disable iff (!arst_n) rd_hit);
    cover property (@(posedge clock) disable iff (!arst_n) wr_commit);
    cover property (@(posedge clock) disable iff (!arst_n) conv_req && stage_ok_q[3]);
endmodule // cacb_bank

// file: dv/cacb_host.sv
`timescale 1ns/10ps
// Host side of the coefficient serial port, one access at a time.
module cacb_host (
    input  wire logic              clock,
    input  wire logic              bit_out,
    output cacb_pkg::cacb_access_t acc,
    output logic                   acc_start,
    output logic                   bit_strobe,
    output logic                   bit_in
);
    ////////////////////////////////////////////////////////////////////////////
    // Idle values; the data line later shows the inverse of its last bit.
    initial begin
        acc_start  = 1'h0;
        acc        = '0;
        bit_strobe = 1'h0;
        bit_in     = 1'h0;
    end

    // Read bits are sampled mid-cycle so they never race the shift edge.
    task automatic xfer(input logic [2:0] a, input logic w, input logic [23:0] wd,
                        output logic [23:0] rd);
        @(posedge clock);
        acc_start <= 1'h1;
        acc       <= '{addr: a, write: w};
        @(posedge clock);
        acc_start <= 1'h0;
        for (int i = 23; i >= 0; i--) begin
            bit_strobe <= 1'h1;
            bit_in     <= wd[i];
            @(negedge clock);
            rd[i] = bit_out;
            @(posedge clock);
        end
        bit_strobe <= 1'h0;
        bit_in     <= ~bit_in;
        repeat (2) @(posedge clock);
    endtask
endmodule // cacb_host

// file: dv/testbench.sv
`timescale 1ns/10ps
module testbench;
    logic                   clock, arst_n, cmd_valid, cmd_calibrate, raw_valid;
    logic                   status_read, acc_start, bit_strobe, bit_in, bit_out;
    logic                   word_done, data_ready_n, read_error_flag, cal_busy;
    logic [23:0]            meas_offset, meas_gain, raw_data, result_data, rd;
    logic [23:0]            stg [4];
    cacb_pkg::cacb_ctrl_t   ctrl;
    cacb_pkg::cacb_access_t acc;
    int                     err_count, cmp_count, done_cnt;

    cacb_bank #(.SYS_CAL_CYCLES(40), .SELF_CAL_CYCLES(60)) cacb_bank_inst (
        .clock(clock), .arst_n(arst_n), .cmd_valid(cmd_valid),
        .cmd_calibrate(cmd_calibrate), .correction_control_register(ctrl),
        .meas_offset(meas_offset), .meas_gain(meas_gain), .raw_valid(raw_valid),
        .raw_data(raw_data), .acc_start(acc_start), .acc(acc),
        .bit_strobe(bit_strobe), .bit_in(bit_in), .status_read(status_read),
        .bit_out(bit_out), .word_done(word_done), .data_ready_n(data_ready_n),
        .result_data(result_data), .read_error_flag(read_error_flag),
        .cal_busy(cal_busy));

    cacb_host cacb_host_inst (.clock(clock), .bit_out(bit_out), .acc(acc),
        .acc_start(acc_start), .bit_strobe(bit_strobe), .bit_in(bit_in));

    ////////////////////////////////////////////////////////////////////////////
    // Clock generation and a watchdog sized well above the whole run.
    initial begin
        clock = 1'h0;
        forever #25 clock = ~clock;
    end

    initial begin
        #(30000 * 50);
        err_count++;
        stop_test();
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared comparison, verdict and bus helpers.
    task automatic check(input string name, input logic [23:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic stop_test();
        if (err_count == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Word completion pulses, counted mid-cycle where they stand settled.
    always @(negedge clock) begin
        if (word_done === 1'h1) begin
            done_cnt++;
        end
    end

    // Each read access must end in exactly one word completion pulse.
    task automatic rdchk(input logic [2:0] a, input logic [23:0] exp);
        int n0;
        n0 = done_cnt;
        cacb_host_inst.xfer(a, 1'h0, 24'h00_0000, rd);
        check("coefficient", rd, exp);
        check("word done", 24'(done_cnt - n0), 24'h00_0001);
    endtask

    task automatic conv();
        @(posedge clock);
        cmd_valid     <= 1'h1;
        cmd_calibrate <= 1'h0;
        @(posedge clock);
        cmd_valid     <= 1'h0;
        @(posedge clock);
    endtask

    // Waits for the ready pulse, which must come on the fifth cycle.
    task automatic res(input logic [3:0] dis, input logic [23:0] raw, exp);
        int n;
        @(posedge clock);
        {ctrl.system_gain_disable, ctrl.system_offset_disable,
         ctrl.selfcal_gain_disable, ctrl.selfcal_offset_disable} <= dis;
        raw_valid <= 1'h1;
        raw_data  <= raw;
        @(posedge clock);
        raw_valid <= 1'h0;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (data_ready_n !== 1'h0 && n < 9);
        check("ready latency", 24'(n), 24'h00_0005);
        check("result", result_data, exp);
    endtask

    // Counts busy cycles; a system offset run also carries a staging write.
    task automatic cal(input logic [1:0] t, input int nexp);
        int n;
        @(posedge clock);
        cmd_valid      <= 1'h1;
        cmd_calibrate  <= 1'h1;
        ctrl.cal_type  <= t;
        @(posedge clock);
        cmd_valid <= 1'h0;
        n = 0;
        fork
            begin
                @(negedge clock);
                while (cal_busy === 1'h1 && n < 100) begin
                    n++;
                    @(negedge clock);
                end
            end
            if (t == 2'h1) cacb_host_inst.xfer(3'h0, 1'h1, 24'h0F_0F0F, rd);
        join
        check("busy cycles", 24'(n), 24'(nexp));
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        {cmd_valid, cmd_calibrate, raw_valid, status_read, arst_n} = '0;
        ctrl        = '0;
        raw_data    = 24'h00_0000;
        meas_offset = 24'h12_3456;
        meas_gain   = 24'h65_4321;
        stg = '{24'h00_0014, 24'h80_0000, 24'h00_0010, 24'h80_0000};
        repeat (4) @(posedge clock);
        arst_n <= 1'h1;
        for (int a = 0; a < 8; a++) rdchk(3'(a), a[0] ? 24'h40_0000 : 24'h00_0000);
        check("read error", 24'(read_error_flag), 24'h00_0000);
        for (int a = 0; a < 4; a++) cacb_host_inst.xfer(3'(a), 1'h1, stg[a], rd);
        cacb_host_inst.xfer(3'h4, 1'h1, 24'hAB_CDEF, rd);
        for (int a = 0; a < 4; a++) rdchk(3'(a), stg[a]);
        rdchk(3'h4, 24'h00_0000);
        conv();
        for (int a = 4; a < 8; a++) rdchk(3'(a), stg[a-4]);
        res(4'hF, 24'h00_0064, 24'h00_0064);
        res(4'hE, 24'h00_0064, 24'h00_005C);
        res(4'hD, 24'h00_0064, 24'h00_00C8);
        res(4'hB, 24'h00_0064, 24'h00_005A);
        res(4'h7, 24'h00_0064, 24'h00_00C8);
        res(4'h0, 24'h00_0064, 24'h00_015C);
        res(4'h0, 24'hFF_FF9C, 24'hFF_FE3C);
        // Unipolar keeps the half-LSB scale, doubling the bipolar result.
        @(posedge clock);
        ctrl.unipolar <= 1'h1;
        res(4'h0, 24'h00_0064, 24'h00_02B8);
        // A working read launched inside the update window must flag.
        fork
            begin
                @(posedge clock);
                raw_valid <= 1'h1;
                @(posedge clock);
                raw_valid <= 1'h0;
            end
            begin
                @(posedge clock);
                cacb_host_inst.xfer(3'h4, 1'h0, 24'h00_0000, rd);
            end
        join
        check("read error", 24'(read_error_flag), 24'h00_0001);
        @(posedge clock);
        status_read <= 1'h1;
        @(posedge clock);
        status_read <= 1'h0;
        @(negedge clock);
        check("read error clear", 24'(read_error_flag), 24'h00_0000);
        cal(2'h1, 40);
        rdchk(3'h0, stg[0]);
        rdchk(3'h4, 24'h12_3456);
        conv();
        rdchk(3'h4, 24'h12_3456);
        cal(2'h2, 40);
        rdchk(3'h5, 24'h65_4321);
        cal(2'h0, 60);
        rdchk(3'h6, 24'h12_3456);
        rdchk(3'h7, 24'h65_4321);
        cal(2'h3, 0);
        stop_test();
    end
endmodule // testbench
